// File: hw/ddc_consts.vh
// Constants for the dual converter parallel-load host controller
`ifndef DDC_CONSTS_VH
`define DDC_CONSTS_VH
// Register offsets of the command port
`define DDC_ADDR_DATA_A   4'h0
`define DDC_ADDR_DATA_B   4'h1
`define DDC_ADDR_CTRL     4'h2
`define DDC_ADDR_CMD      4'h3
`define DDC_ADDR_STATUS   4'h4
// Control register fields
`define DDC_CTRL_GAIN     0
`define DDC_CTRL_BUF      1
`define DDC_CTRL_PWR      2
`define DDC_CTRL_SYNC     3
// Command register fields
`define DDC_CMD_WRA       0
`define DDC_CMD_WRB       1
`define DDC_CMD_UPD       2
`define DDC_CMD_CLR       3
// Status fields
`define DDC_ST_BUSY       0
`define DDC_ST_WAKE       1
`define DDC_ST_PWR        2
// Pin timing at 40 MHz
`define DDC_CLK_MHZ       40
`define DDC_STROBE_CYC    3'h2
`define DDC_SETUP_CYC     3'h1
`define DDC_WAKE_NS_5V    2500
`define DDC_WAKE_NS_3V    5000
`endif

// File: hw/ddc_wake_timer.v
// Wake-delay timer after the power-down pin is released
`timescale 1ns/1ps
`default_nettype none
module ddc_wake_timer #(
   parameter CYC_W = 16
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             rst_n,
   // Control
   input  wire             start,
   input  wire             abort,
   input  wire [CYC_W-1:0] cycles,
   // Status
   output reg              waking_r
);
   reg [CYC_W-1:0] cnt_r;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r    <= {CYC_W{1'b0}};
         waking_r <= 1'b0;
      end else if (abort) begin
         cnt_r    <= {CYC_W{1'b0}};
         waking_r <= 1'b0;
      end else if (start) begin
         cnt_r    <= cycles;
         waking_r <= 1'b1;
      end else if (waking_r) begin
         if (cnt_r <= {{(CYC_W-1){1'b0}}, 1'b1})
            waking_r <= 1'b0;
         cnt_r <= cnt_r - {{(CYC_W-1){1'b0}}, 1'b1};
      end
   end
endmodule
`default_nettype wire

// File: hw/ddc_host_ctrl.v
// Host controller driving a dual parallel-load converter over its pins
//
// Functional notes
// - Bus at least data width wide
// - Ten-bit: gain bit 10, buffer 11
// - Twelve-bit: gain bit 12, buffer 13
// - Shared byte select reaches right register
// - Chip select stable while address changes
// - Update held low gives synchronous mode; with sync_r the code pulses update once after the queued channel writes are all done instead
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ddc_consts.vh"
module ddc_host_ctrl #(
   parameter RES       = 12,
   parameter TWO_BYTE  = 0,
   parameter BUS_W     = 16,
   parameter WAKE_5V   = 1,
   parameter WAKE_CYC  = WAKE_5V ? (`DDC_WAKE_NS_5V * `DDC_CLK_MHZ / 1000)
                                 : (`DDC_WAKE_NS_3V * `DDC_CLK_MHZ / 1000)
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             rst_n,
   // Command port
   input  wire [3:0]       cmd_addr,
   input  wire [15:0]      cmd_wdata,
   input  wire             cmd_wr,
   input  wire             cmd_rd,
   output reg  [15:0]      cmd_rdata_r,
   // Converter pins
   output reg  [BUS_W-1:0] data_line_r,
   output reg              channel_select_r,
   output reg              upper_byte_select_r,
   output reg              chip_select_n_r,
   output reg              write_n_r,
   output reg              update_strobe_n_r,
   output reg              clear_n_r,
   output reg              power_down_n_r
);
   localparam ST_IDLE  = 6'h01;
   localparam ST_SETUP = 6'h02;
   localparam ST_LOW   = 6'h04;
   localparam ST_HOLD  = 6'h08;
   localparam ST_UPD   = 6'h10;
   localparam ST_CLR   = 6'h20;
   localparam DW       = (RES > 12) ? 12 : RES;

   reg [5:0]    st_r;
   reg [2:0]    cnt_r;
   reg [11:0]   data_a_r;
   reg [11:0]   data_b_r;
   reg          gain_r;
   reg          bufen_r;
   reg          sync_r;
   reg [1:0]    pend_r;
   reg          upd_pend_r;
   reg          clr_pend_r;
   reg          chan_r;
   reg          byte_r;
   reg [15:0]   word;
   wire         waking;
   wire [15:0]  wake_cyc = WAKE_CYC[15:0];
   wire         cmd_hit  = cmd_wr && (cmd_addr == `DDC_ADDR_CMD);

   ddc_wake_timer #(.CYC_W(16)) u_wake (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .start    (cmd_wr && cmd_addr == `DDC_ADDR_CTRL && cmd_wdata[`DDC_CTRL_PWR]
                 && !power_down_n_r),
      .abort    (cmd_wr && cmd_addr == `DDC_ADDR_CTRL && !cmd_wdata[`DDC_CTRL_PWR]),
      .cycles   (wake_cyc),
      .waking_r (waking)
   );

   // Bus word for the pending transfer
   always @* begin
      word = 16'h0000;
      if (TWO_BYTE != 0) begin
         if (byte_r)
            word = {8'h00, 2'b00, bufen_r, gain_r, (chan_r ? data_b_r[11:8] : data_a_r[11:8])};
         else
            word = {8'h00, (chan_r ? data_b_r[7:0] : data_a_r[7:0])};
      end else begin
         word[DW-1:0] = chan_r ? data_b_r[DW-1:0] : data_a_r[DW-1:0];
         word[DW]     = gain_r;
         word[DW+1]   = bufen_r;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r                <= ST_IDLE;
         cnt_r               <= 3'h0;
         data_a_r            <= 12'h000;
         data_b_r            <= 12'h000;
         gain_r              <= 1'b0;
         bufen_r             <= 1'b0;
         sync_r              <= 1'b0;
         pend_r              <= 2'b00;
         upd_pend_r          <= 1'b0;
         clr_pend_r          <= 1'b0;
         chan_r              <= 1'b0;
         byte_r              <= 1'b0;
         cmd_rdata_r         <= 16'h0000;
         data_line_r         <= {BUS_W{1'b0}};
         channel_select_r    <= 1'b0;
         upper_byte_select_r <= 1'b0;
         chip_select_n_r     <= 1'b1;
         write_n_r           <= 1'b1;
         update_strobe_n_r   <= 1'b1;
         clear_n_r           <= 1'b1;
         power_down_n_r      <= 1'b1;
      end else begin
         // Register writes; sets from software only
         if (cmd_wr) begin
            case (cmd_addr)
               `DDC_ADDR_DATA_A: data_a_r <= cmd_wdata[11:0];
               `DDC_ADDR_DATA_B: data_b_r <= cmd_wdata[11:0];
               `DDC_ADDR_CTRL: begin
                  gain_r         <= cmd_wdata[`DDC_CTRL_GAIN];
                  bufen_r        <= cmd_wdata[`DDC_CTRL_BUF];
                  sync_r         <= cmd_wdata[`DDC_CTRL_SYNC];
                  power_down_n_r <= cmd_wdata[`DDC_CTRL_PWR];
               end
               default: ;
            endcase
         end
         // Command read-back
         if (cmd_rd) begin
            case (cmd_addr)
               `DDC_ADDR_DATA_A: cmd_rdata_r <= {4'h0, data_a_r};
               `DDC_ADDR_DATA_B: cmd_rdata_r <= {4'h0, data_b_r};
               `DDC_ADDR_CTRL:   cmd_rdata_r <= {12'h000, sync_r, power_down_n_r,
                                                 bufen_r, gain_r};
               `DDC_ADDR_STATUS: cmd_rdata_r <= {13'h0, power_down_n_r, waking,
                                                 (st_r != ST_IDLE) | (|pend_r)
                                                 | upd_pend_r | clr_pend_r};
               default:          cmd_rdata_r <= 16'h0000;
            endcase
         end
         // Commands queue even while busy; a new set beats a same-cycle clear
         if (cmd_hit) begin
            pend_r     <= pend_r | {cmd_wdata[`DDC_CMD_WRB], cmd_wdata[`DDC_CMD_WRA]};
            upd_pend_r <= upd_pend_r | cmd_wdata[`DDC_CMD_UPD];
            clr_pend_r <= clr_pend_r | cmd_wdata[`DDC_CMD_CLR];
         end
         case (st_r)
            ST_IDLE: begin
               chip_select_n_r   <= 1'b1;
               write_n_r         <= 1'b1;
               update_strobe_n_r <= 1'b1;
               clear_n_r         <= 1'b1;
               cnt_r             <= `DDC_SETUP_CYC;
               if (clr_pend_r) begin
                  clr_pend_r <= cmd_hit & cmd_wdata[`DDC_CMD_CLR];
                  clear_n_r  <= 1'b0;
                  cnt_r      <= `DDC_STROBE_CYC;
                  st_r       <= ST_CLR;
               end else if (|pend_r) begin
                  chan_r           <= ~pend_r[0];
                  channel_select_r <= ~pend_r[0];
                  byte_r           <= 1'b0;
                  st_r             <= ST_SETUP;
               end else if (upd_pend_r) begin
                  upd_pend_r        <= cmd_hit & cmd_wdata[`DDC_CMD_UPD];
                  update_strobe_n_r <= 1'b0;
                  cnt_r             <= `DDC_STROBE_CYC;
                  st_r              <= ST_UPD;
               end
            end
            ST_SETUP: begin
               // Lines frozen once select falls; late register writes cannot move them
               if (cnt_r == 3'h0) begin
                  chip_select_n_r <= 1'b0;
                  write_n_r       <= 1'b0;
                  cnt_r           <= `DDC_STROBE_CYC;
                  st_r            <= ST_LOW;
               end else begin
                  upper_byte_select_r <= byte_r;
                  data_line_r         <= word[BUS_W-1:0];
                  cnt_r               <= cnt_r - 3'h1;
               end
            end
            ST_LOW: begin
               if (cnt_r == 3'h0) begin
                  write_n_r <= 1'b1;
                  cnt_r     <= `DDC_SETUP_CYC;
                  st_r      <= ST_HOLD;
               end else
                  cnt_r <= cnt_r - 3'h1;
            end
            ST_HOLD: begin
               if (cnt_r == 3'h0) begin
                  chip_select_n_r <= 1'b1;
                  if (TWO_BYTE != 0 && !byte_r) begin
                     byte_r <= 1'b1;
                     cnt_r  <= `DDC_SETUP_CYC;
                     st_r   <= ST_SETUP;
                  end else begin
                     if (chan_r)
                        pend_r[1] <= cmd_hit & cmd_wdata[`DDC_CMD_WRB];
                     else
                        pend_r[0] <= cmd_hit & cmd_wdata[`DDC_CMD_WRA];
                     if (sync_r)
                        upd_pend_r <= 1'b1;
                     st_r <= ST_IDLE;
                  end
               end else
                  cnt_r <= cnt_r - 3'h1;
            end
            ST_UPD, ST_CLR: begin
               if (cnt_r == 3'h0) begin
                  update_strobe_n_r <= 1'b1;
                  clear_n_r         <= 1'b1;
                  st_r              <= ST_IDLE;
               end else
                  cnt_r <= cnt_r - 3'h1;
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: tb/ddc_host_ctrl_chk.sv
// Pin and command port assertions for the host controller
`timescale 1ns/1ps
`default_nettype none
module ddc_host_ctrl_chk #(parameter BUS_W = 16) (
   // Clock and command port
   input wire logic             clk_sys,
   input wire logic             rst_n,
   input wire logic             cmd_wr,
   // Converter pins
   input wire logic [BUS_W-1:0] data_line_r,
   input wire logic             channel_select_r,
   input wire logic             chip_select_n_r,
   input wire logic             write_n_r,
   input wire logic             update_strobe_n_r,
   input wire logic             clear_n_r,
   input wire logic             power_down_n_r
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_write_needs_cs: assert property ($fell(write_n_r) |-> !chip_select_n_r)
      else $error("write strobe without chip select");
   a_cs_past_rise: assert property ($rose(write_n_r) |-> !chip_select_n_r ##1 !chip_select_n_r)
      else $error("chip select left before write rise");
   a_data_steady: assert property (!chip_select_n_r |-> $stable(data_line_r) && $stable(channel_select_r))
      else $error("data or channel moved while selected");
   a_load_clear_high: assert property ($rose(write_n_r) |-> clear_n_r && update_strobe_n_r)
      else $error("write edge during clear or update");
   a_clear_pulse: assert property ($fell(clear_n_r) |-> !clear_n_r[*3] ##1 clear_n_r)
      else $error("clear pulse width wrong");
   a_update_pulse: assert property ($fell(update_strobe_n_r) |-> !update_strobe_n_r[*3] ##1 update_strobe_n_r)
      else $error("update pulse width wrong");
   a_clear_alone: assert property (!clear_n_r |-> write_n_r && update_strobe_n_r)
      else $error("clear overlaps other strobes");
   a_pd_by_write: assert property ($changed(power_down_n_r) |-> $past(cmd_wr) || $past(cmd_wr, 2))
      else $error("power-down pin moved without a write");
   c_write: cover property ($rose(write_n_r));
   c_update: cover property ($fell(update_strobe_n_r));
   c_clear: cover property ($fell(clear_n_r));
   c_power_down: cover property ($fell(power_down_n_r));
endmodule
bind ddc_host_ctrl ddc_host_ctrl_chk #(.BUS_W(BUS_W)) i_ddc_host_ctrl_chk (.clk_sys, .rst_n,
   .cmd_wr, .data_line_r, .channel_select_r, .chip_select_n_r, .write_n_r, .update_strobe_n_r,
   .clear_n_r, .power_down_n_r);
`default_nettype wire

// File: tb/ddc_dev_model.sv
// Behavioural model of the dual parallel-load converter
`timescale 1ns/1ps
`default_nettype none
module ddc_dev_model (
   // Pins from the controller
   input  wire logic [15:0] data_line,
   input  wire logic        channel_select,
   input  wire logic        chip_select_n,
   input  wire logic        write_n,
   input  wire logic        update_strobe_n,
   input  wire logic        clear_n,
   input  wire logic        power_down_n,
   // Output codes, floating when off
   output wire logic [11:0] vout_a,
   output wire logic [11:0] vout_b
);
   // Bit 13 buffer, bit 12 gain
   logic [13:0] in_a, in_b, out_a, out_b;
   logic        new_a, new_b;
   initial {in_a, in_b, out_a, out_b, new_a, new_b} = '0;
   always @(negedge clear_n) {in_a, in_b, out_a, out_b, new_a, new_b} = '0;
   always @(posedge write_n) if (clear_n && !chip_select_n) begin
      if (channel_select) {in_b, new_b} = {data_line[13:0], 1'b1};
      else {in_a, new_a} = {data_line[13:0], 1'b1};
   end
   // delay lets a write land first
   always @(negedge update_strobe_n or posedge write_n) #1 if (clear_n && !update_strobe_n) begin
      if (new_a) out_a = in_a;
      if (new_b) out_b = in_b;
      {new_a, new_b} = 2'h0;
   end
   assign vout_a = power_down_n ? out_a[11:0] : 12'hZZZ;
   assign vout_b = power_down_n ? out_b[11:0] : 12'hZZZ;
endmodule
`default_nettype wire

// File: tb/ddc_host_ctrl_bench.sv
// Self-checking bench for the host controller
`timescale 1ns/1ps
`default_nettype none
module ddc_host_ctrl_bench;
   logic        clk_sys = 0, rst_n = 0, cmd_wr = 0, cmd_rd = 0;
   logic [3:0]  cmd_addr = 4'h0;
   logic [15:0] cmd_wdata = 16'h0000, cmd_rdata_r, data_line_r;
   logic        channel_select_r, upper_byte_select_r, chip_select_n_r, write_n_r;
   logic        update_strobe_n_r, clear_n_r, power_down_n_r;
   logic [11:0] vout_a, vout_b;
   int          mismatches = 0, checks = 0;
   always #12.5 clk_sys = ~clk_sys;
   // Short wake count keeps the run brief
   ddc_host_ctrl #(.WAKE_CYC(4)) i_ddc_host_ctrl (.clk_sys, .rst_n, .cmd_addr, .cmd_wdata,
      .cmd_wr, .cmd_rd, .cmd_rdata_r, .data_line_r, .channel_select_r, .upper_byte_select_r,
      .chip_select_n_r, .write_n_r, .update_strobe_n_r, .clear_n_r, .power_down_n_r);
   ddc_dev_model i_ddc_dev_model (.data_line(data_line_r), .channel_select(channel_select_r),
      .chip_select_n(chip_select_n_r), .write_n(write_n_r), .update_strobe_n(update_strobe_n_r),
      .clear_n(clear_n_r), .power_down_n(power_down_n_r), .vout_a, .vout_b);
   task give_verdict;
      if (mismatches == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys) {cmd_addr, cmd_wdata, cmd_wr} <= {a, d, 1'b1};
      @(posedge clk_sys) cmd_wr <= 1'b0;
   endtask
   // Read data appear in the cycle after the strobe and hold until the next read
   task rd(input logic [3:0] a);
      @(posedge clk_sys) {cmd_addr, cmd_rd} <= {a, 1'b1};
      @(posedge clk_sys) cmd_rd <= 1'b0;
      #1;
   endtask
   task idle;
      int n;
      repeat (4) @(posedge clk_sys);
      for (n = 0; n < 300; n++) begin
         rd(4'h4);
         if (cmd_rdata_r[0] === 1'b0) return;
      end
      mismatches++;
      give_verdict;
   endtask
   task t_reset;
      chk({chip_select_n_r, write_n_r, update_strobe_n_r, clear_n_r, power_down_n_r}, 16'h001F);
      chk(i_ddc_dev_model.out_a, 16'h0000);
      chk(vout_b, 16'h0000);
      chk(i_ddc_dev_model.in_a, 16'h0000);
   endtask
   task t_load;
      wr(4'h2, 16'h0007);
      wr(4'h0, 16'h0ABC);
      wr(4'h1, 16'h0FFF);
      wr(4'h3, 16'h0003);
      idle;
      chk(i_ddc_dev_model.in_a, 16'h3ABC);
      chk(upper_byte_select_r, 1'b0);
      chk(i_ddc_dev_model.in_b, 16'h3FFF);
      chk(i_ddc_dev_model.out_a, 16'h0000);
      wr(4'h3, 16'h0004);
      idle;
      chk({i_ddc_dev_model.out_b[13:12], vout_a}, 16'h3ABC);
   endtask
   task t_power;
      wr(4'h2, 16'h0003);
      rd(4'h4);
      chk(cmd_rdata_r[2], 1'b0);
      chk(vout_b, 16'h0ZZZ);
      wr(4'h2, 16'h0007);
      rd(4'h4);
      chk(cmd_rdata_r[1], 1'b1);
      repeat (10) @(posedge clk_sys);
      rd(4'h4);
      chk(cmd_rdata_r[1], 1'b0);
      chk(vout_b, 16'h0FFF);
      rd(4'hF);
      chk(cmd_rdata_r, 16'h0000);
   endtask
   task t_clear_sync;
      wr(4'h3, 16'h0008);
      idle;
      chk(i_ddc_dev_model.in_b, 16'h0000);
      chk(i_ddc_dev_model.out_b, 16'h0000);
      chk(vout_a, 16'h0000);
      wr(4'h2, 16'h000C);
      wr(4'h0, 16'h0555);
      wr(4'h3, 16'h0001);
      idle;
      chk(i_ddc_dev_model.out_a, 16'h0555);
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset;
      t_load;
      t_power;
      t_clear_sync;
      give_verdict;
   end
endmodule
`default_nettype wire
